// ---- lmcr_ctl.sv ----
/*
 Legacy-mode card read and select-out control: select-out holding,
 deferred feed window, stacker select, end of file and op-code steps.
 Assumes one 200 MHz clock, synchronous inputs, a microprogram that
 drives the one-cycle request strobes, and a register port master.
*/
// Functional notes
// - Emulation: hold select out past channel end to release
// - Tape and file always run burst
// - Native-mode resets gated off in emulation
// - Emulation clears: recycle, select in, release
// - Release ignores the K parity bit
// - Recycle from system reset or service request
// - Release issued once channel end sensed
// - Combined op steps 27, 25, 24, 20
// - Op decode latches switch byte before start
// - Native read sends data, no card move
// - Emulation feed starts 6 ms after read data
// - Stacker select in window feeds and selects
// - Feed-and-select cancels the deferred feed
// - Sense first; no attention means window expired
// - Expired: no select, load code 7F
// - Native end of file needs extra read
// - Emulation end of file with last channel end
// - Device characters use the interchange code
`timescale 1ns/1ps
`include "lmcr_defs.svh"

module lmcr_ctl #(
   parameter int CLK_HZ = `LMCR_CLK_HZ,
   parameter int WINDOW_MS = `LMCR_FEED_WINDOW_MS,
   parameter int WINDOW_CYC = (CLK_HZ / 1000) * WINDOW_MS
) (
   input wire logic clk_i, // 200 MHz clock
   input wire logic rst_b_i, // Async reset, active low
   input wire logic emul_mode_i, // High in legacy emulation mode
   input wire logic svc_mode_i, // Engineering service mode
   input wire logic recycle_req_i, // Recycle reset request pulse
   input wire logic [7:0] mode_switch_byte_i, // Mode-switch control byte
   input wire lmcr_pkg::lmcr_io_start_t io_start_i, // Op decode start request
   input wire logic native_so_reset_i, // Ordinary native reset of select out
   input wire logic select_in_i, // Select in from channel
   input wire logic channel_end_i, // Channel end pulse from channel
   input wire logic last_card_i, // Reader reports last card
   input wire lmcr_pkg::lmcr_k_to_fb_t k_to_fb_i, // Microprogram release statement
   input wire logic read_data_start_i, // Read data transfer began
   input wire logic stacker_sel_i, // Legacy stacker select sensed
   input wire logic [1:0] stacker_num_i, // Chosen stacker
   input wire logic [7:0] op_code_i, // Converted op code to load
   input wire logic op_load_i, // Load op code pulse
   input wire logic print_done_i, // Print phase complete
   input wire logic read_done_i, // Read phase complete
   input wire logic punch_done_i, // Punch phase complete
   input wire logic [7:0] reg_addr_i, // Register port address
   input wire logic [7:0] reg_wdata_i, // Register port write data
   input wire logic reg_wr_i, // Register write strobe
   input wire logic reg_rd_i, // Register read strobe
   output logic [7:0] reg_rdata_o, // Read data, cycle after strobe
   output logic select_out_o, // Channel select out
   output logic recycle_reset_o, // Recycle reset level: one cycle per request in service mode, held during system reset
   output lmcr_pkg::lmcr_cmd_t dev_cmd_o, // Command to card unit
   output logic [1:0] dev_stacker_o, // Stacker for feed-and-select
   output logic burst_o, // Burst mode forced
   output logic eof_o, // End of file indicator
   output logic [7:0] op_code_o, // Bit-significant op code
   output logic [7:0] operator_code_register_o, // Operator-visible R register
   output logic window_open_o, // Deferred feed window open
   output logic start_io_o // Start I/O after setup
);
   localparam logic [31:0] WIN_W = 32'(WINDOW_CYC);

   logic [31:0] win_cnt_reg;
   logic feed_pend_reg;
   logic sel_req_reg;
   logic sel_sense_reg;
   logic [1:0] sel_stk_reg;
   logic eof_arm_reg;
   logic extra_read_reg;
   logic [7:0] mode_byte_reg;
   logic setup_reg;
   lmcr_pkg::lmcr_dev_t dev_reg;
   logic k_release;
   logic rec_next;
   logic attn;

   // Parity bit 8 is ignored; zero or one data bit set releases
   assign k_release = k_to_fb_i.valid && ($countones(k_to_fb_i.k_value[7:0]) <= 1);
   assign rec_next = ~rst_b_i ? 1'b0 : (recycle_req_i && svc_mode_i);
   assign attn = (win_cnt_reg != 32'h0000_0000);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         recycle_reset_o <= 1'b1;
      end else begin
         recycle_reset_o <= rec_next;
      end
   end

   // Op decode: latch mode byte and device, start I/O one cycle later
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode_byte_reg <= `LMCR_OPR_RESET;
         setup_reg <= 1'b0;
         start_io_o <= 1'b0;
         dev_reg <= lmcr_pkg::LMCR_DEV_READER;
      end else begin
         start_io_o <= setup_reg;
         setup_reg <= io_start_i.start;
         if (io_start_i.start) begin
            mode_byte_reg <= mode_switch_byte_i;
            dev_reg <= io_start_i.dev;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         burst_o <= 1'b0;
      end else begin
         burst_o <= (dev_reg == lmcr_pkg::LMCR_DEV_TAPE_FILE) || emul_mode_i;
      end
   end

   // Select out: set at start, only restricted clears in emulation
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         select_out_o <= 1'b0;
      end else if (recycle_reset_o || select_in_i) begin
         select_out_o <= 1'b0;
      end else if (emul_mode_i) begin
         if (k_release) begin
            select_out_o <= 1'b0;
         end else if (setup_reg) begin
            select_out_o <= 1'b1;
         end
      end else if (native_so_reset_i || k_release || channel_end_i) begin
         select_out_o <= 1'b0;
      end else if (setup_reg) begin
         select_out_o <= 1'b1;
      end
   end

   // Deferred feed window counter
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         win_cnt_reg <= 32'h0000_0000;
         feed_pend_reg <= 1'b0;
      end else if (recycle_reset_o) begin
         win_cnt_reg <= 32'h0000_0000;
         feed_pend_reg <= 1'b0;
      end else if (emul_mode_i && read_data_start_i) begin
         win_cnt_reg <= WIN_W;
         feed_pend_reg <= 1'b1;
      end else if (sel_req_reg && sel_sense_reg && attn) begin
         win_cnt_reg <= 32'h0000_0000;
         feed_pend_reg <= 1'b0;
      end else if (win_cnt_reg > 32'h0000_0001) begin
         win_cnt_reg <= win_cnt_reg - 32'h0000_0001;
      end else if (win_cnt_reg == 32'h0000_0001) begin
         win_cnt_reg <= 32'h0000_0000;
      end else begin
         feed_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         window_open_o <= 1'b0;
      end else begin
         window_open_o <= attn;
      end
   end

   // Stacker select: sense, then feed-and-select or flag the code
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sel_req_reg <= 1'b0;
         sel_sense_reg <= 1'b0;
         sel_stk_reg <= 2'h0;
      end else if (stacker_sel_i && emul_mode_i && !sel_req_reg) begin
         sel_req_reg <= 1'b1;
         sel_sense_reg <= 1'b0;
         sel_stk_reg <= stacker_num_i;
      end else if (sel_req_reg && !sel_sense_reg) begin
         sel_sense_reg <= 1'b1;
      end else if (sel_req_reg) begin
         sel_req_reg <= 1'b0;
         sel_sense_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dev_cmd_o <= '0;
         dev_stacker_o <= 2'h0;
      end else if (sel_req_reg && !sel_sense_reg) begin
         dev_cmd_o <= '{valid: 1'b1, cmd: `LMCR_CMD_SENSE};
      end else if (sel_req_reg && attn) begin
         dev_cmd_o <= '{valid: 1'b1, cmd: `LMCR_CMD_FEED_SEL};
         dev_stacker_o <= sel_stk_reg;
      end else if (feed_pend_reg && win_cnt_reg == 32'h0000_0001) begin
         dev_cmd_o <= '{valid: 1'b1, cmd: `LMCR_CMD_FEED};
         dev_stacker_o <= 2'h0;
      end else if (!emul_mode_i && setup_reg && dev_reg == lmcr_pkg::LMCR_DEV_READER) begin
         dev_cmd_o <= '{valid: 1'b1, cmd: `LMCR_CMD_READ};
      end else begin
         dev_cmd_o <= '0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         operator_code_register_o <= `LMCR_OPR_RESET;
      end else if (sel_req_reg && sel_sense_reg && !attn) begin
         // Hardware flag wins over a software write in the same cycle
         operator_code_register_o <= `LMCR_CODE_BAD_STACKER;
      end else if (reg_wr_i && reg_addr_i == 8'h00) begin
         operator_code_register_o <= reg_wdata_i;
      end
   end

   // End of file
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         eof_arm_reg <= 1'b0;
         extra_read_reg <= 1'b0;
         eof_o <= 1'b0;
      end else if (op_load_i) begin
         eof_o <= 1'b0;
         eof_arm_reg <= 1'b0;
         extra_read_reg <= 1'b0;
      end else begin
         if (last_card_i) begin
            eof_arm_reg <= 1'b1;
         end
         if (emul_mode_i && channel_end_i && (last_card_i || eof_arm_reg)) begin
            eof_o <= 1'b1;
         end else if (!emul_mode_i && eof_arm_reg && setup_reg && !extra_read_reg) begin
            extra_read_reg <= 1'b1;
         end else if (!emul_mode_i && extra_read_reg && channel_end_i) begin
            eof_o <= 1'b1;
         end
      end
   end

   // Bit-significant op code progression
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         op_code_o <= `LMCR_OP_DONE;
      end else if (op_load_i) begin
         op_code_o <= op_code_i;
      end else begin
         if (print_done_i) begin
            op_code_o[`LMCR_OP_BIT_PRINT] <= 1'b0;
         end
         if (read_done_i) begin
            op_code_o[`LMCR_OP_BIT_READ] <= 1'b0;
         end
         if (punch_done_i) begin
            op_code_o[`LMCR_OP_BIT_PUNCH] <= 1'b0;
         end
      end
   end

   // Register read port; data pass through unconverted
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            8'h00: reg_rdata_o <= operator_code_register_o;
            8'h01: reg_rdata_o <= op_code_o;
            8'h02: reg_rdata_o <= {5'h00, eof_o, attn, select_out_o};
            8'h03: reg_rdata_o <= mode_byte_reg;
            default: reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end
endmodule

// ---- lmcr_defs.svh ----
/*
 Timing counts, op codes and field positions for the legacy-mode
 card read and select-out control block.
 Assumes inclusion by bare name from the block's design file.
*/
`ifndef LMCR_DEFS_SVH
`define LMCR_DEFS_SVH

`define LMCR_CLK_HZ 200000000
`define LMCR_FEED_WINDOW_MS 6
`define LMCR_OP_PRT_RD_PCH 8'h27
`define LMCR_OP_RD_PCH 8'h25
`define LMCR_OP_PCH 8'h24
`define LMCR_OP_DONE 8'h20
`define LMCR_OP_BIT_PRINT 1
`define LMCR_OP_BIT_READ 0
`define LMCR_OP_BIT_PUNCH 2
`define LMCR_CODE_BAD_STACKER 8'h7F
`define LMCR_STAT_ATTN_BIT 0
`define LMCR_OPR_RESET 8'h00
`define LMCR_CMD_SENSE 8'h04
`define LMCR_CMD_FEED_SEL 8'h0B
`define LMCR_CMD_FEED 8'h03
`define LMCR_CMD_READ 8'h02

`endif

// ---- lmcr_pkg.sv ----
/*
 Types for the legacy-mode card read and select-out control block.
 Assumes the constants header is included by the design file.
*/
package lmcr_pkg;
   typedef enum logic [1:0] {
      LMCR_DEV_READER,
      LMCR_DEV_PRINTER,
      LMCR_DEV_PUNCH,
      LMCR_DEV_TAPE_FILE
   } lmcr_dev_t;

   typedef struct packed {
      logic start;
      lmcr_dev_t dev;
   } lmcr_io_start_t;

   typedef struct packed {
      logic valid;
      logic [7:0] cmd;
   } lmcr_cmd_t;

   typedef struct packed {
      logic valid;
      logic [7:0] status;
   } lmcr_status_t;

   typedef struct packed {
      logic valid;
      logic [8:0] k_value;
   } lmcr_k_to_fb_t;
endpackage

// ---- lmcr_ctl_chk.sv ----
/* Port checker for lmcr_ctl, bound in below.
   Assumes one clock and the async active-low reset of the block. */
`timescale 1ns/1ps
module lmcr_ctl_chk (
   input wire logic clk_i, // clock
   input wire logic rst_b_i, // reset
   input wire logic emul_mode_i, // mode
   input wire logic svc_mode_i, // service
   input wire logic recycle_req_i, // recycle ask
   input wire lmcr_pkg::lmcr_io_start_t io_start_i, // start
   input wire logic select_in_i, // select in
   input wire lmcr_pkg::lmcr_k_to_fb_t k_to_fb_i, // release
   input wire logic read_data_start_i, // data began
   input wire logic stacker_sel_i, // stacker ask
   input wire logic print_done_i, // print end
   input wire logic select_out_o, // select out
   input wire logic recycle_reset_o, // recycle
   input wire lmcr_pkg::lmcr_cmd_t dev_cmd_o, // command
   input wire logic burst_o, // burst
   input wire logic [7:0] op_code_o, // op code
   input wire logic [7:0] operator_code_register_o, // R reg
   input wire logic window_open_o, // window
   input wire logic start_io_o // start io
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   logic rel;
   // Parity bit 8 is left out of the count on purpose
   assign rel = k_to_fb_i.valid && $countones(k_to_fb_i.k_value[7:0]) <= 1;
   chk_so_held: assert property (
      emul_mode_i && select_out_o && !rel && !select_in_i && !recycle_reset_o
      && !recycle_req_i |=> select_out_o) else $error("select out dropped early");
   chk_release_clr: assert property (
      emul_mode_i && rel && !io_start_i.start |=> !select_out_o)
      else $error("release kept select out");
   chk_selin_clr: assert property (
      select_in_i && !io_start_i.start |=> !select_out_o) else $error("select in ignored");
   chk_recycle_gen: assert property (
      recycle_req_i && svc_mode_i |=> recycle_reset_o) else $error("no recycle reset");
   chk_start_seq: assert property (
      io_start_i.start |-> ##2 start_io_o && select_out_o) else $error("start io late");
   chk_tape_burst: assert property (
      io_start_i.start && io_start_i.dev == lmcr_pkg::LMCR_DEV_TAPE_FILE |-> ##[1:2] burst_o)
      else $error("tape not burst");
   chk_sense_first: assert property (
      stacker_sel_i && emul_mode_i |-> ##2 dev_cmd_o.valid && dev_cmd_o.cmd == 8'h04)
      else $error("no sense");
   chk_late_code: assert property (
      stacker_sel_i && emul_mode_i && !window_open_o && !read_data_start_i |-> ##3
      operator_code_register_o == 8'h7F && !(dev_cmd_o.valid && dev_cmd_o.cmd == 8'h0B))
      else $error("late select not flagged");
   chk_op_step: assert property (
      op_code_o == 8'h27 && print_done_i |=> op_code_o == 8'h25) else $error("op step");
   cov_release: cover property (emul_mode_i && rel);
   cov_feed_sel: cover property (dev_cmd_o.valid && dev_cmd_o.cmd == 8'h0B);
   cov_late: cover property (stacker_sel_i && !window_open_o);
endmodule
bind lmcr_ctl lmcr_ctl_chk u_chk (.*);

// ---- lmcr_card_model.sv ----
/* Card unit model at the far side of the device command port.
   Assumes bench requests as one-cycle pulses set at a rising edge. */
`timescale 1ns/1ps
module lmcr_card_model (
   input wire logic clk_i, // clock
   input wire lmcr_pkg::lmcr_cmd_t dev_cmd_i, // command
   input wire logic [1:0] dev_stacker_i, // stacker
   input wire logic go_i, // read a card
   input wire logic last_i, // it is the last
   input wire logic fault_i, // unit fault
   input wire logic [3:0] dly_i, // cycles to channel end
   output logic read_data_start_o, // data began
   output logic channel_end_o, // channel end
   output logic last_card_o, // last card
   output logic select_in_o, // fault only
   output int feed_cnt_o, // deferred feeds
   output int fsel_cnt_o, // feed and selects
   output logic [1:0] stacker_o // stacker used
);
   int step = 0;
   logic lst = 1'b0;
   initial begin
      feed_cnt_o = 0;
      fsel_cnt_o = 0;
      stacker_o = 2'b00;
   end
   always @(posedge clk_i) begin
      read_data_start_o <= go_i;
      channel_end_o <= step == 1;
      last_card_o <= step == 1 && lst;
      select_in_o <= fault_i;
      step <= go_i ? int'(dly_i) : (step > 0 ? step - 1 : 0);
      if (go_i) lst <= last_i;
      if (dev_cmd_i.valid && dev_cmd_i.cmd == 8'h03) feed_cnt_o <= feed_cnt_o + 1;
      if (dev_cmd_i.valid && dev_cmd_i.cmd == 8'h0B) begin
         fsel_cnt_o <= fsel_cnt_o + 1;
         stacker_o <= dev_stacker_i;
      end
   end
endmodule

// ---- lmcr_ctl_test.sv ----
/* Self-checking bench for lmcr_ctl with the card unit model.
   Assumes the checker is bound from its own file; window shortened. */
`timescale 1ns/1ps
module lmcr_ctl_test;
   localparam int WC = 50;
   localparam int RQ = 0, NR = 1, SS = 2, OL = 3, PD = 4, GO = 7, FL = 8, IO = 9, KF = 10;
   logic clk_i = 0, rst_b_i = 0, emul_mode_i = 0, svc_mode_i = 0, reg_wr_i = 0, reg_rd_i = 0;
   logic recycle_req_i, native_so_reset_i, stacker_sel_i, op_load_i, print_done_i;
   logic read_done_i, punch_done_i, go, flt, lst = 0;
   logic [10:0] p = '0;
   logic [8:0] kv = '0;
   logic [7:0] mode_switch_byte_i = 0, op_code_i = 0, reg_addr_i = 0, reg_wdata_i = 0, d;
   logic [1:0] stacker_num_i = 0, dev_stacker_o, stk;
   logic [3:0] dly = 4'h2;
   lmcr_pkg::lmcr_dev_t dv = lmcr_pkg::LMCR_DEV_READER;
   lmcr_pkg::lmcr_io_start_t io_start_i;
   lmcr_pkg::lmcr_k_to_fb_t k_to_fb_i;
   lmcr_pkg::lmcr_cmd_t dev_cmd_o;
   logic select_in_i, channel_end_i, last_card_i, read_data_start_i, select_out_o;
   logic recycle_reset_o, burst_o, eof_o, window_open_o, start_io_o;
   logic [7:0] reg_rdata_o, op_code_o, operator_code_register_o;
   int fails = 0, check_count = 0, nf, ns, ef = 0, es = 0, cc = 0, t0 = 0, t1 = 0, e;
   logic [7:0] q[$] = '{8'h25, 8'h24, 8'h20};
   assign {flt, go, punch_done_i, read_done_i, print_done_i, op_load_i} = p[8:3];
   assign {stacker_sel_i, native_so_reset_i, recycle_req_i} = p[2:0];
   assign io_start_i = {p[IO], dv};
   assign k_to_fb_i = {p[KF], kv};
   lmcr_ctl #(.WINDOW_CYC(WC)) u_dut (.*);
   lmcr_card_model u_card (.clk_i(clk_i), .dev_cmd_i(dev_cmd_o), .dev_stacker_i(dev_stacker_o),
      .go_i(go), .last_i(lst), .fault_i(flt), .dly_i(dly), .read_data_start_o(read_data_start_i),
      .channel_end_o(channel_end_i), .last_card_o(last_card_i), .select_in_o(select_in_i),
      .feed_cnt_o(nf), .fsel_cnt_o(ns), .stacker_o(stk));
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   // Time stamps let the feed delay be judged without peeking inside
   always @(posedge clk_i) begin
      cc <= cc + 1;
      if (read_data_start_i) t0 <= cc;
      if (dev_cmd_o.valid && dev_cmd_o.cmd == 8'h03) t1 <= cc;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      check_count++;
      if (s !== x) begin
         fails++;
         $display("CHECK FAILED %s exp %h got %h", n, x, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic pls(input int b);
      @(posedge clk_i) p[b] <= 1'b1;
      @(posedge clk_i) p[b] <= 1'b0;
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input string n, input logic [7:0] x);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(n, reg_rdata_o, x);
   endtask
   task automatic summarize;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      void'($urandom(24021));
      d = 8'($urandom);
      mode_switch_byte_i = 8'($urandom);
      cyc(16);
      rst_b_i <= 1'b1;
      cyc(2);
      chk("op reset", op_code_o, 8'h20);
      rd(8'h00, "opr reset", 8'h00);
      emul_mode_i <= 1'b1;
      pls(IO);
      cyc(2);
      rd(8'h03, "mode byte", mode_switch_byte_i);
      lst <= 1'b1;
      dly <= 4'(2 + $urandom % 8);
      pls(GO);
      cyc(12);
      chk("eof emul", eof_o, 1'b1);
      pls(NR);
      chk("so held", select_out_o, 1'b1);
      kv <= 9'h102;
      pls(KF);
      cyc(1);
      chk("so release", select_out_o, 1'b0);
      rd(8'h02, "status", 8'h06);
      for (e = 0; nf == ef && e < 3 * WC; e++) cyc(1);
      if (nf == ef) begin
         chk("feed timeout", nf, ef + 1);
         summarize();
      end
      ef++;
      chk("feed delay", t1 - t0 >= WC - 1 && t1 - t0 <= WC + 2, 1'b1);
      pls(IO);
      cyc(2);
      kv <= 9'h003;
      pls(KF);
      chk("two bits", select_out_o, 1'b1);
      pls(FL);
      cyc(2);
      chk("select in", select_out_o, 1'b0);
      svc_mode_i <= 1'b1;
      pls(IO);
      cyc(2);
      pls(RQ);
      cyc(2);
      chk("recycle", select_out_o, 1'b0);
      svc_mode_i <= 1'b0;
      pls(IO);
      cyc(2);
      pls(RQ);
      cyc(1);
      chk("no recycle", {recycle_reset_o, select_out_o}, 2'b01);
      kv <= 9'h000;
      pls(KF);
      lst <= 1'b0;
      pls(GO);
      cyc(5);
      stacker_num_i <= 2'($urandom);
      pls(SS);
      cyc(3);
      es++;
      chk("fsel", ns, es);
      chk("stacker", stk, stacker_num_i);
      cyc(WC + 10);
      chk("feed cancelled", nf, ef);
      pls(SS);
      cyc(3);
      chk("late fsel", ns, es);
      rd(8'h00, "bad stacker", 8'h7F);
      emul_mode_i <= 1'b0;
      // Clear the end-of-file state left by the emulation run
      pls(OL);
      pls(IO);
      cyc(2);
      lst <= 1'b1;
      pls(GO);
      cyc(12);
      chk("native ce", {select_out_o, eof_o, window_open_o}, 3'b000);
      pls(IO);
      cyc(2);
      lst <= 1'b0;
      pls(GO);
      cyc(12);
      chk("extra read", eof_o, 1'b1);
      cyc(2 * WC);
      chk("no native feed", nf, ef);
      dv <= lmcr_pkg::LMCR_DEV_TAPE_FILE;
      pls(IO);
      cyc(2);
      chk("tape burst", burst_o, 1'b1);
      op_code_i <= 8'h27;
      pls(OL);
      chk("op load", {op_code_o, eof_o}, 9'h04E);
      for (int i = 0; i < 3; i++) begin
         pls(PD + i);
         chk("op step", op_code_o, q[i]);
      end
      wr(8'h01, d);
      rd(8'h01, "op ro", 8'h20);
      rd(8'hA5, "unmapped", 8'h00);
      wr(8'h00, d);
      rd(8'h00, "opr rw", d);
      summarize();
   end
endmodule
